// ---- dv/ceeu_core_monitor.sv ----
// ceeu_core_monitor: port assertions for the exception unit.
// assumes: bound to ceeu_core, one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none
`include "ceeu_map.svh"
module ceeu_core_monitor
    import ceeu_pkg::*;
#(
    parameter logic [31:0] VEC_BASE = 32'h0000_0000
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ext_irq,
    input wire ceeu_retire_t retire,
    input wire ceeu_bus_t bus,
    input wire logic [31:0] bus_rdata,
    input wire ceeu_redir_t redirect,
    input wire ceeu_take_t taken,
    input wire logic [31:0] machine_state_word
);
    // ==========================================================
    // entry and return checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [31:0] clr;
    logic [31:0] msw;
    assign clr = `CEEU_MSW_CLR;
    assign msw = machine_state_word;
    AST_EXT_VEC: assert property (
        taken == CEEU_TK_EXT |-> !msw[15] &&
        redirect.pc == (VEC_BASE | 32'h0000_0500)) else $error("ext");
    AST_EE_GATE: assert property (
        taken == CEEU_TK_EXT |-> $past(msw[15])) else $error("gate");
    AST_ENTRY_MSW: assert property (
        taken != CEEU_TK_NONE |-> (msw & clr) == 32'h0 &&
        (msw & ~clr) == ($past(msw) & ~clr)) else $error("msw");
    AST_ILLEGAL: assert property (
        retire.valid && retire.op inside {CEEU_OP_ILLEG, CEEU_OP_FLOAT}
        |=> taken == CEEU_TK_PRG) else $error("illegal");
    AST_TRAP: assert property (
        retire.valid && retire.op == CEEU_OP_TRAP && retire.trap_hit
        |=> taken == CEEU_TK_PRG &&
        redirect.pc == (VEC_BASE | 32'h0000_0700)) else $error("trap");
    AST_ALIGN: assert property (
        retire.valid && retire.op == CEEU_OP_DCBZ && retire.no_cache &&
        !retire.priv_only |=> taken == CEEU_TK_ALN &&
        redirect.pc == (VEC_BASE | 32'h0000_0600)) else $error("align");
    AST_ONE_TAKE: assert property (
        $onehot(taken) && (taken == CEEU_TK_NONE || redirect.valid))
        else $error("take");
    AST_RETURN: assert property (
        retire.valid && retire.op == CEEU_OP_RETNC && !retire.priv_only
        |=> redirect.valid && taken == CEEU_TK_NONE) else $error("ret");
    // main scenarios seen
    COV_EXT: cover property (taken == CEEU_TK_EXT);
    COV_ALN: cover property (taken == CEEU_TK_ALN);
    COV_PRG: cover property (taken == CEEU_TK_PRG);
endmodule // ceeu_core_monitor
bind ceeu_core ceeu_core_monitor #(.VEC_BASE(VEC_BASE)) u_mon (
    .clk_sys(clk_sys), .rst(rst), .ext_irq(ext_irq), .retire(retire),
    .bus(bus), .bus_rdata(bus_rdata), .redirect(redirect),
    .taken(taken), .machine_state_word(machine_state_word));
`default_nettype wire

// ---- dv/ceeu_irq_ctl.sv ----
// ceeu_irq_ctl: external interrupt controller model.
// assumes: raise and clear come from the handler side.
`timescale 1ns/1ns
`default_nettype none
module ceeu_irq_ctl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic raise,
    input wire logic clear,
    output logic ext_irq
);
    // ==========================================================
    // request held until its status is cleared
    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
            ext_irq <= 1'b0;
        end else if (raise) begin
            ext_irq <= 1'b1;
        end
    end
endmodule // ceeu_irq_ctl
`default_nettype wire

// ---- dv/test_core_exception_entry_unit.sv ----
// test_core_exception_entry_unit: directed bench for ceeu_core.
// assumes: package, map header and controller model compiled.
`timescale 1ns/1ns
`default_nettype none
`include "ceeu_map.svh"
module test_core_exception_entry_unit
    import ceeu_pkg::*;
;
    localparam logic [31:0] VB = 32'h0001_0000;
    logic clk_sys = 1'b0, rst = 1'b1, raise = 1'b0, clear = 1'b0;
    logic ext_irq;
    ceeu_retire_t retire = '0;
    ceeu_bus_t bus = '0;
    logic [31:0] bus_rdata, msw;
    ceeu_redir_t redirect;
    ceeu_take_t taken;
    int err_total = 0, check_count = 0;
    always #4 clk_sys = ~clk_sys;
    ceeu_irq_ctl u_irq (.clk_sys(clk_sys), .rst(rst), .raise(raise),
        .clear(clear), .ext_irq(ext_irq));
    ceeu_core #(.VEC_BASE(VB)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .ext_irq(ext_irq), .retire(retire), .bus(bus),
        .bus_rdata(bus_rdata), .redirect(redirect), .taken(taken),
        .machine_state_word(msw));
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys) bus.we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_sys) bus.re <= 1'b0;
        #1 chk(bus_rdata, e);
    endtask
    task automatic ret(input ceeu_op_t op, input logic po, input logic th,
                       input logic nc, input logic [31:0] ea);
        @(posedge clk_sys) retire <= '{1'b1, op, po, th, nc, 32'h100,
                                      32'h104, ea};
        @(posedge clk_sys) retire.valid <= 1'b0;
        #1;
    endtask
    task automatic pin(input logic up);
        @(posedge clk_sys) begin
            raise <= up;
            clear <= !up;
        end
        @(posedge clk_sys) {raise, clear} <= 2'b00;
        repeat (3) @(posedge clk_sys);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_ext();
        wr(`CEEU_OFF_MSW, 32'h0);
        pin(1'b1);
        ret(CEEU_OP_PLAIN, 1'b0, 1'b0, 1'b0, 32'h0);
        chk(taken, CEEU_TK_NONE);
        wr(`CEEU_OFF_MSW, 32'hFFFF_FFFF);
        ret(CEEU_OP_PLAIN, 1'b0, 1'b0, 1'b0, 32'h0);
        chk(taken, CEEU_TK_EXT);
        chk(redirect.pc, VB | 32'h0500);
        chk(msw, ~`CEEU_MSW_CLR);
        rd(`CEEU_OFF_SRA, 32'h104);
        rd(`CEEU_OFF_SMS, 32'hFFFF_FFFF);
        ret(CEEU_OP_PLAIN, 1'b0, 1'b0, 1'b0, 32'h0);
        chk(taken, CEEU_TK_NONE);
        wr(`CEEU_OFF_MSW, 32'h8000);
        ret(CEEU_OP_PLAIN, 1'b0, 1'b0, 1'b0, 32'h0);
        chk(taken, CEEU_TK_EXT);
        // synchronous fault beside a pending request: only one taken
        wr(`CEEU_OFF_MSW, 32'h8000);
        ret(CEEU_OP_ILLEG, 1'b0, 1'b0, 1'b0, 32'h0);
        chk(taken, CEEU_TK_PRG);
        rd(`CEEU_OFF_SMS, 32'h8000);
        ret(CEEU_OP_PLAIN, 1'b0, 1'b0, 1'b0, 32'h0);
        chk(taken, CEEU_TK_NONE);
        pin(1'b0);
        wr(`CEEU_OFF_MSW, 32'h8000);
        ret(CEEU_OP_PLAIN, 1'b0, 1'b0, 1'b0, 32'h0);
        chk(taken, CEEU_TK_NONE);
        $display("t_ext done");
    endtask
    task automatic t_prg();
        ceeu_op_t op[4] = '{CEEU_OP_ILLEG, CEEU_OP_FLOAT, CEEU_OP_PLAIN,
                            CEEU_OP_TRAP};
        logic [31:0] esy[4] = '{32'h8800_0000, 32'h8800_0000,
                                32'h8400_0000, 32'h8200_0000};
        for (int i = 0; i < 4; i++) begin
            wr(`CEEU_OFF_MSW, 32'h4000);
            wr(`CEEU_OFF_ESY, 32'hFFFF_FFFF);
            ret(op[i], i == 2, i == 3, 1'b0, 32'h0);
            chk(taken, CEEU_TK_PRG);
            chk(redirect.pc, VB | 32'h0700);
            rd(`CEEU_OFF_ESY, esy[i]);
            rd(`CEEU_OFF_SRA, 32'h100);
        end
        $display("t_prg done");
    endtask
    task automatic t_aln();
        ceeu_op_t op[4] = '{CEEU_OP_DCBZ, CEEU_OP_LRSV, CEEU_OP_STCND,
                            CEEU_OP_DCREAD};
        for (int i = 0; i < 4; i++) begin
            wr(`CEEU_OFF_MSW, 32'h0);
            ret(op[i], 1'b0, 1'b0, i == 0, 32'h200 + i);
            chk(taken, CEEU_TK_ALN);
            chk(redirect.pc, VB | 32'h0600);
            rd(`CEEU_OFF_DFA, 32'h200 + i);
            rd(`CEEU_OFF_SRA, 32'h100);
        end
        wr(`CEEU_OFF_MSW, 32'h4000);
        ret(CEEU_OP_DCREAD, 1'b0, 1'b0, 1'b0, 32'h203);
        chk(taken, CEEU_TK_NONE);
        $display("t_aln done");
    endtask
    task automatic t_ret();
        // trap handler moves the return past the trap
        ret(CEEU_OP_TRAP, 1'b0, 1'b1, 1'b0, 32'h0);
        wr(`CEEU_OFF_SRA, 32'h104);
        ret(CEEU_OP_RETNC, 1'b0, 1'b0, 1'b0, 32'h0);
        chk(redirect.pc, 32'h104);
        wr(`CEEU_OFF_SRA, 32'h1234);
        wr(`CEEU_OFF_SMS, 32'h9000);
        ret(CEEU_OP_RETNC, 1'b0, 1'b0, 1'b0, 32'h0);
        chk(redirect.pc, 32'h1234);
        chk(redirect.valid, 1'b1);
        chk(msw, 32'h9000);
        $display("t_ret done");
    endtask
    // reset in mid-run: state word and saved return address back to zero
    task automatic t_rst();
        wr(`CEEU_OFF_SRA, 32'h5555_0000);
        @(posedge clk_sys) rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk(msw, `CEEU_MSW_RST);
        chk(taken, CEEU_TK_NONE);
        chk(redirect.valid, 1'b0);
        rd(`CEEU_OFF_SRA, 32'h0);
        $display("t_rst done");
    endtask
    // ==========================================================
    // verdict
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`CEEU_OFF_MSW, 32'h0);
        t_ext();
        t_prg();
        t_aln();
        t_ret();
        t_rst();
        tally_and_finish();
    end
endmodule // test_core_exception_entry_unit
`default_nettype wire

// ---- hw/ceeu_core.sv ----
// ceeu_core: exception entry for the external, alignment and
// program interrupts, with the saved state registers.
// assumes: one clock, one completing instruction per cycle at
// most, the interrupt pin asynchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "ceeu_map.svh"

// What this block does
// - pin request takes external vector 0x0500
// - enable bit gates pin; clear ignores it
// - level request re-taken while held, enabled
// - external entry clears the async enable
// - external saves next sequential address
// - entry copies whole state word to save
// - entry zeroes listed fields, keeps others
// - zero-block on uncached memory aligns, 0x0600
// - unaligned reserve/conditional, privileged dcread
// - alignment exceptions cannot be masked
// - alignment saves own address, operand address
// - illegal and floating instructions, 0x0700
// - privileged instruction in user mode faults
// - satisfied trap saves its own address
// - program sets exactly one cause bit
// - program keeps machine check bit, clears rest
// - coprocessor and unit error causes stay clear
// - program exceptions cannot be masked
// - return restores address and state word
module ceeu_core
    import ceeu_pkg::*;
#(
    parameter logic [31:0] VEC_BASE = 32'h0000_0000
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ext_irq,
    input wire ceeu_retire_t retire,
    input wire ceeu_bus_t bus,
    output logic [31:0] bus_rdata,
    output ceeu_redir_t redirect,
    output ceeu_take_t taken,
    output logic [31:0] machine_state_word
);

    // ==========================================================
    // helper functions

    // word alignment of an operand address
    function automatic logic is_unaligned(input logic [31:0] a);
        is_unaligned = (a[1:0] != 2'b00);
    endfunction

    // state word after entry: listed fields zeroed
    function automatic logic [31:0] entry_msw(input logic [31:0] m);
        entry_msw = m & ~`CEEU_MSW_CLR;
    endfunction

    // register read decode
    function automatic logic [31:0] reg_read(
        input ceeu_state_t s,
        input logic [7:0] a
    );
        unique case (a)
            `CEEU_OFF_MSW: reg_read = s.msw;
            `CEEU_OFF_SRA: reg_read = s.sra;
            `CEEU_OFF_SMS: reg_read = s.sms;
            `CEEU_OFF_ESY: reg_read = s.esy;
            `CEEU_OFF_DFA: reg_read = s.dfa;
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction

    // ==========================================================
    // state and decode signals

    ceeu_state_t s_q;
    ceeu_state_t s_d;
    logic user_mode;
    logic ext_ok;
    logic prg_ill;
    logic prg_prv;
    logic prg_trp;
    logic aln_hit;
    logic prg_hit;
    logic [31:0] prg_esy;

    // ==========================================================
    // cause decode of the completing instruction

    always_comb begin
        user_mode = s_q.msw[`CEEU_MSW_PR];
        // floating point counts as illegal here
        prg_ill = retire.valid && (retire.op == CEEU_OP_ILLEG ||
            retire.op == CEEU_OP_FLOAT);
        prg_prv = retire.valid && !prg_ill && retire.priv_only &&
            user_mode;
        prg_trp = retire.valid && !prg_ill && !prg_prv &&
            retire.op == CEEU_OP_TRAP && retire.trap_hit;
        // no enable bit appears in any synchronous term
        prg_hit = prg_ill || prg_prv || prg_trp;
        aln_hit = 1'b0;
        if (retire.valid && !prg_ill && !prg_prv) begin
            unique case (retire.op)
                CEEU_OP_DCBZ:
                    aln_hit = retire.no_cache;
                CEEU_OP_LRSV, CEEU_OP_STCND:
                    aln_hit = is_unaligned(retire.ea);
                CEEU_OP_DCREAD:
                    aln_hit = !user_mode &&
                        is_unaligned(retire.ea);
                default:
                    aln_hit = 1'b0;
            endcase
        end
        // alignment has no mask either
        aln_hit = aln_hit && !prg_hit;
        // program syndrome: one cause, machine check kept
        prg_esy = 32'h0000_0000;
        prg_esy[`CEEU_ESY_MCI] = s_q.esy[`CEEU_ESY_MCI];
        prg_esy[`CEEU_ESY_PIL] = prg_ill;
        prg_esy[`CEEU_ESY_PPR] = prg_prv;
        prg_esy[`CEEU_ESY_PTR] = prg_trp;
        // coprocessor and unit error causes never raised
        prg_esy[`CEEU_ESY_PEU] = 1'b0;
        prg_esy[`CEEU_ESY_PFP] = 1'b0;
        prg_esy[`CEEU_ESY_PAP] = 1'b0;
        // external only at a clean boundary, not on a return
        ext_ok = s_q.irq_s2 && s_q.msw[`CEEU_MSW_EE] &&
            retire.valid && !prg_hit && !aln_hit &&
            retire.op != CEEU_OP_RETNC;
    end

    // ==========================================================
    // next state

    always_comb begin
        s_d = s_q;
        // two-flop synchroniser on the request pin
        s_d.irq_s1 = ext_irq;
        s_d.irq_s2 = s_q.irq_s1;
        s_d.redir = '0;
        s_d.taken = CEEU_TK_NONE;
        // read data stands the cycle after the strobe
        s_d.rdata = bus.re ? reg_read(s_q, bus.addr) : 32'h0000_0000;
        // software writes, overridden below by any entry that loads the same register
        if (bus.we) begin
            unique case (bus.addr)
                `CEEU_OFF_MSW: s_d.msw = bus.wdata;
                `CEEU_OFF_SRA: s_d.sra = bus.wdata;
                `CEEU_OFF_SMS: s_d.sms = bus.wdata;
                `CEEU_OFF_ESY: s_d.esy = bus.wdata;
                `CEEU_OFF_DFA: s_d.dfa = bus.wdata;
                default: s_d.sra = s_d.sra;
            endcase
        end
        // priority: program, alignment, external; one per cycle
        if (prg_hit) begin
            s_d.sra = retire.pc;
            s_d.sms = s_q.msw;
            s_d.msw = entry_msw(s_q.msw);
            s_d.esy = prg_esy;
            s_d.redir.valid = 1'b1;
            s_d.redir.pc = VEC_BASE | `CEEU_VEC_PRG;
            s_d.taken = CEEU_TK_PRG;
        end else if (aln_hit) begin
            s_d.sra = retire.pc;
            s_d.dfa = retire.ea;
            s_d.sms = s_q.msw;
            s_d.msw = entry_msw(s_q.msw);
            s_d.redir.valid = 1'b1;
            s_d.redir.pc = VEC_BASE | `CEEU_VEC_ALN;
            s_d.taken = CEEU_TK_ALN;
        end else if (ext_ok) begin
            // level request: re-taken at each enabled boundary
            s_d.sra = retire.next_pc;
            s_d.sms = s_q.msw;
            // enable cleared with the rest of the entry fields
            s_d.msw = entry_msw(s_q.msw);
            s_d.redir.valid = 1'b1;
            s_d.redir.pc = VEC_BASE | `CEEU_VEC_EXT;
            s_d.taken = CEEU_TK_EXT;
        end else if (retire.valid && retire.op == CEEU_OP_RETNC) begin
            s_d.msw = s_q.sms;
            s_d.redir.valid = 1'b1;
            s_d.redir.pc = s_q.sra;
        end
    end

    // ==========================================================
    // state register

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
            s_q.msw <= `CEEU_MSW_RST;
            s_q.taken <= CEEU_TK_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs, all from flops

    assign bus_rdata = s_q.rdata;
    assign redirect = s_q.redir;
    assign taken = s_q.taken;
    assign machine_state_word = s_q.msw;

endmodule // ceeu_core
`default_nettype wire

// ---- inc/ceeu_map.svh ----
// ceeu_map.svh: offsets, bit positions, vectors and masks for the
// exception entry unit.
// assumes: included by bare name, after the package.
`ifndef CEEU_MAP_SVH
`define CEEU_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define CEEU_OFF_MSW 8'h00
`define CEEU_OFF_SRA 8'h04
`define CEEU_OFF_SMS 8'h08
`define CEEU_OFF_ESY 8'h0C
`define CEEU_OFF_DFA 8'h10

// ==========================================================
// vector offsets
`define CEEU_VEC_EXT 32'h0000_0500
`define CEEU_VEC_ALN 32'h0000_0600
`define CEEU_VEC_PRG 32'h0000_0700

// ==========================================================
// machine state word bit positions
`define CEEU_MSW_EE 15
`define CEEU_MSW_PR 14
// fields zeroed on entry; critical, machine check and debug
// enables (bits 17, 12, 9) are kept
`define CEEU_MSW_CLR 32'h020C_ED30
`define CEEU_MSW_RST 32'h0000_0000

// ==========================================================
// exception syndrome bit positions
`define CEEU_ESY_MCI 31
`define CEEU_ESY_PIL 27
`define CEEU_ESY_PPR 26
`define CEEU_ESY_PTR 25
`define CEEU_ESY_PFP 24
`define CEEU_ESY_PAP 23
`define CEEU_ESY_PEU 22

`endif

// ---- inc/ceeu_pkg.sv ----
// ceeu_pkg: types of the exception entry unit.
// assumes: compiled before any design file.
package ceeu_pkg;

    // completing instruction class
    typedef enum logic [3:0] {
        CEEU_OP_PLAIN  = 4'h0,
        CEEU_OP_DCBZ   = 4'h1,
        CEEU_OP_LRSV   = 4'h2,
        CEEU_OP_STCND  = 4'h3,
        CEEU_OP_DCREAD = 4'h4,
        CEEU_OP_ILLEG  = 4'h5,
        CEEU_OP_FLOAT  = 4'h6,
        CEEU_OP_TRAP   = 4'h7,
        CEEU_OP_RETNC  = 4'h8
    } ceeu_op_t;

    // exception being taken, one-hot
    typedef enum logic [3:0] {
        CEEU_TK_NONE = 4'b0001,
        CEEU_TK_EXT  = 4'b0010,
        CEEU_TK_ALN  = 4'b0100,
        CEEU_TK_PRG  = 4'b1000
    } ceeu_take_t;

    // instruction at the completion boundary
    typedef struct packed {
        logic valid;
        ceeu_op_t op;
        logic priv_only;
        logic trap_hit;
        logic no_cache;
        logic [31:0] pc;
        logic [31:0] next_pc;
        logic [31:0] ea;
    } ceeu_retire_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } ceeu_bus_t;

    // redirect to the fetch unit
    typedef struct packed {
        logic valid;
        logic [31:0] pc;
    } ceeu_redir_t;

    // whole module state
    typedef struct packed {
        logic irq_s1;
        logic irq_s2;
        logic [31:0] msw;
        logic [31:0] sra;
        logic [31:0] sms;
        logic [31:0] esy;
        logic [31:0] dfa;
        logic [31:0] rdata;
        ceeu_redir_t redir;
        ceeu_take_t taken;
    } ceeu_state_t;

endpackage
